// *** tb_tbp_port.sv ***
// Purpose: self-checking bench for the three-pin port
// Assumes: pin inputs settle through the synchroniser within eight cycles
// Notes: direction is tracked in a shadow since it reads back as ones
`timescale 1ns/1ps
module tb_tbp_port;
    import tbp_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    tbp_mux_s mux_ctl = '0;
    tbp_ser_out_s ser_out = '0;
    tbp_pmode_e pmode = PM_ACTIVE;
    logic [2:0] ext_lvl = 3'h0;
    logic [2:0] pin_i;
    logic [2:0] pin_o;
    logic [2:0] pin_oe;
    logic ser_rxd;
    logic ser_sck_in;
    logic [7:0] dir_shadow = 8'h00;
    logic [2:0] clk_cfg [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6};
    int n_errors = 0;
    int n_tests = 0;

    always #50 core_clk = ~core_clk;

    tbp_port i_tbp_port (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .mux_ctl(mux_ctl), .ser_out(ser_out), .pmode(pmode), .pin_i(pin_i),
        .pin_o(pin_o), .pin_oe(pin_oe), .ser_rxd(ser_rxd), .ser_sck_in(ser_sck_in));
    tbp_pins_model i_tbp_pins_model (.pin_o(pin_o), .pin_oe(pin_oe), .ext_lvl(ext_lvl),
        .pin_i(pin_i));

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd_chk(input string what, input logic [15:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(what, exp, reg_rdata);
    endtask : rd_chk

    // whole values from the shadow, never read-modify-write
    task automatic set_dir(input logic [7:0] d);
        dir_shadow = d;
        wr(OFS_DIR, dir_shadow);
    endtask : set_dir

    task automatic settle;
        repeat (8) @(posedge core_clk);
        #1;
    endtask : settle

    initial begin
        repeat (5000) @(posedge core_clk);
        n_errors++;
        finish_test();
    end

    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        settle();
        chk("oe at reset", 8'h00, {5'h00, pin_oe});
        rd_chk("latch at reset", OFS_LATCH, 8'h00);
        rd_chk("dir read", OFS_DIR, DIR_READ_VAL);
        set_dir(8'h07);
        wr(OFS_LATCH, 8'hFD);
        settle();
        chk("oe output", 8'h07, {5'h00, pin_oe});
        chk("pin out", 8'h05, {5'h00, pin_o});
        rd_chk("latch out", OFS_LATCH, 8'h05);
        rd_chk("dir after write", OFS_DIR, 8'hFF);
        ext_lvl <= 3'h6;
        set_dir(8'h03);
        settle();
        rd_chk("latch mixed", OFS_LATCH, 8'h05);
        set_dir(8'h00);
        settle();
        rd_chk("latch input", OFS_LATCH, 8'h06);
        rd_chk("unmapped", 16'hFFD4, RD_UNMAPPED);
        set_dir(8'h07);
        ext_lvl <= 3'h1;
        mux_ctl.tx_sel <= 1'b1;
        mux_ctl.rx_on_bit <= 1'b1;
        ser_out.sck_out <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            {mux_ctl.clk_src_sel_hi, mux_ctl.clk_src_sel_lo, mux_ctl.sync_sel_bit} <= clk_cfg[i];
            settle();
            chk("serial oe", {5'h00, 1'b1, 1'b0, ~clk_cfg[i][2]}, {5'h00, pin_oe});
            chk("txd and rxd", 8'h00, {6'h00, pin_o[2], ser_rxd});
            chk("clk pin", {5'h00, ~clk_cfg[i][2], ~clk_cfg[i][2] & ~|clk_cfg[i][1:0],
                clk_cfg[i][2]}, {5'h00, pin_oe[0], pin_oe[0] & pin_o[0], ser_sck_in});
        end
        mux_ctl <= '0;
        settle();
        chk("rxd idle", 8'h01, {7'h00, ser_rxd});
        pmode <= PM_SLEEP;
        wr(OFS_LATCH, 8'h00);
        settle();
        chk("sleep hold", 8'h05, {5'h00, pin_o});
        pmode <= PM_WATCH;
        wr(OFS_LATCH, 8'h02);
        settle();
        chk("watch hold", 8'h05, {5'h00, pin_o});
        pmode <= PM_SUBSLEEP;
        wr(OFS_LATCH, 8'h00);
        settle();
        chk("subsleep hold", 8'h05, {5'h00, pin_o});
        pmode <= PM_STANDBY;
        settle();
        chk("standby oe", 8'h00, {5'h00, pin_oe});
        pmode <= PM_SUBACTIVE;
        settle();
        chk("subactive oe", 8'h07, {5'h00, pin_oe});
        rst <= 1'b1;
        ext_lvl <= 3'h0;
        settle();
        chk("oe in reset", 8'h00, {5'h00, pin_oe});
        rst <= 1'b0;
        settle();
        rd_chk("latch re-reset", OFS_LATCH, 8'h00);
        finish_test();
    end
endmodule : tb_tbp_port

// *** tbp_pins_model.sv ***
// Purpose: far-side pin model for the three-pin port
// Assumes: plain levels, no pull resistors on the board
// Notes: an undriven pin shows the level the bench asks for
`timescale 1ns/1ps
module tbp_pins_model
    import tbp_pkg::*;
(
    input wire logic [NPINS-1:0] pin_o,
    input wire logic [NPINS-1:0] pin_oe,
    input wire logic [NPINS-1:0] ext_lvl,
    output logic [NPINS-1:0] pin_i
);
    always_comb begin
        for (int k = 0; k < NPINS; k++) begin
            pin_i[k] = pin_oe[k] ? pin_o[k] : ext_lvl[k];
        end
    end
endmodule : tbp_pins_model

// *** tbp_pkg.sv ***
// Purpose: shared constants and types for the three-pin port with serial muxing
// Assumes: byte-wide register port, 16-bit addresses
// Notes: power modes arrive as an encoded input from the system controller
package tbp_pkg;
    localparam int NPINS = 3;
    localparam logic [15:0] OFS_LATCH = 16'hFFD5;
    localparam logic [15:0] OFS_DIR = 16'hFFE5;
    localparam logic [2:0] RST_LATCH = 3'h0;
    localparam logic [2:0] RST_DIR = 3'h0;
    localparam logic [7:0] DIR_READ_VAL = 8'hFF;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;
    localparam int PIN_TX = 2;
    localparam int PIN_RX = 1;
    localparam int PIN_CLK = 0;

    typedef enum logic [2:0] {
        PM_ACTIVE,
        PM_SUBACTIVE,
        PM_SLEEP,
        PM_SUBSLEEP,
        PM_WATCH,
        PM_STANDBY
    } tbp_pmode_e;

    // serial-side controls that steer pin ownership
    typedef struct packed {
        logic tx_sel;
        logic rx_on_bit;
        logic clk_src_sel_hi;
        logic clk_src_sel_lo;
        logic sync_sel_bit;
    } tbp_mux_s;

    // serial-side data exchanged with the pins
    typedef struct packed {
        logic txd;
        logic sck_out;
    } tbp_ser_out_s;

    typedef struct packed {
        logic [NPINS-1:0] o;
        logic [NPINS-1:0] oe;
    } tbp_pin_drv_s;
endpackage : tbp_pkg

// *** tbp_port.sv ***
// Function
// - three bidirectional pins 0..2, each usable as general input or output
// - latch holds bits 2..0; bits 7..3 read zero, ignore writes
// - direction 1: latch read returns stored latch bit
// - direction 0: latch read returns sampled pin level
// - direction 1 drives latch value out; 0 makes pin an input
// - direction and latch act only while serial function is deselected
// - direction register is write-only and reads all ones
// - reset clears latch and direction; all pins start as inputs
// - transmit select makes pin 2 serial transmit output
// - receive enable makes pin 1 serial receive input
// - pin 0: general, clock output, or clock input by clock selects
// - high-z in reset/standby, hold in sleep modes, normal when active
//
// Purpose: three-pin general I/O port with serial transmit/receive/clock muxing
// Assumes: register port with read data one cycle after the read strobe
// Notes: pin outputs are registered, so pins follow register writes one cycle later
`timescale 1ns/1ps
module tbp_port
    import tbp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire tbp_mux_s mux_ctl,
    input wire tbp_ser_out_s ser_out,
    input wire tbp_pmode_e pmode,
    input wire logic [NPINS-1:0] pin_i,
    output logic [NPINS-1:0] pin_o,
    output logic [NPINS-1:0] pin_oe,
    output logic ser_rxd,
    output logic ser_sck_in
);
    logic [2:0] latch_q;
    logic [2:0] dir_q;
    logic [NPINS-1:0] pin_sync;
    logic [NPINS-1:0] pin_held_q;
    logic [NPINS-1:0] alt_sel;
    logic [7:0] rdata_d;
    logic sck_out_mode;
    logic sck_in_mode;
    logic hold_mode;
    logic hiz_mode;
    tbp_pin_drv_s drv_d;

    genvar gi;
    generate
        for (gi = 0; gi < NPINS; gi++) begin : g_sync
            tbp_sync3 u_sync (
                .core_clk(core_clk),
                .rst(rst),
                .din(pin_i[gi]),
                .dout(pin_sync[gi])
            );
        end
    endgenerate

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            latch_q <= RST_LATCH;
        end else if (reg_wr && reg_addr == OFS_LATCH) begin
            latch_q <= reg_wdata[2:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dir_q <= RST_DIR;
        end else if (reg_wr && reg_addr == OFS_DIR) begin
            dir_q <= reg_wdata[2:0];
        end
    end

    always_comb begin
        sck_in_mode = mux_ctl.clk_src_sel_hi;
        sck_out_mode = !mux_ctl.clk_src_sel_hi
            && (mux_ctl.clk_src_sel_lo || mux_ctl.sync_sel_bit);
    end

    always_comb begin
        alt_sel = '0;
        alt_sel[PIN_TX] = mux_ctl.tx_sel;
        alt_sel[PIN_RX] = mux_ctl.rx_on_bit;
        alt_sel[PIN_CLK] = sck_in_mode || sck_out_mode;
    end

    always_comb begin
        hold_mode = (pmode == PM_SLEEP) || (pmode == PM_SUBSLEEP) || (pmode == PM_WATCH);
        hiz_mode = (pmode == PM_STANDBY);
    end

    always_comb begin
        drv_d.o = latch_q;
        drv_d.oe = dir_q;
        if (mux_ctl.tx_sel) begin
            drv_d.o[PIN_TX] = ser_out.txd;
            drv_d.oe[PIN_TX] = 1'b1;
        end
        if (mux_ctl.rx_on_bit) begin
            drv_d.o[PIN_RX] = 1'b0;
            drv_d.oe[PIN_RX] = 1'b0;
        end
        if (sck_in_mode) begin
            drv_d.o[PIN_CLK] = 1'b0;
            drv_d.oe[PIN_CLK] = 1'b0;
        end else if (sck_out_mode) begin
            drv_d.o[PIN_CLK] = ser_out.sck_out;
            drv_d.oe[PIN_CLK] = 1'b1;
        end
    end

    // pin state per power mode; reset also floats pins
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pin_o <= '0;
            pin_oe <= '0;
        end else if (hiz_mode) begin
            pin_o <= '0;
            pin_oe <= '0;
        end else if (!hold_mode) begin
            pin_o <= drv_d.o;
            pin_oe <= drv_d.oe;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pin_held_q <= '0;
        end else if (!hold_mode) begin
            pin_held_q <= pin_sync;
        end
    end

    // receive and clock inputs to the serial block
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ser_rxd <= 1'b1;
            ser_sck_in <= 1'b0;
        end else begin
            ser_rxd <= mux_ctl.rx_on_bit ? pin_held_q[PIN_RX] : 1'b1;
            ser_sck_in <= sck_in_mode ? pin_held_q[PIN_CLK] : 1'b0;
        end
    end

    always_comb begin
        rdata_d = RD_UNMAPPED;
        if (reg_addr == OFS_LATCH) begin
            rdata_d = {5'h00, (dir_q & latch_q) | (~dir_q & pin_held_q)};
        end else if (reg_addr == OFS_DIR) begin
            rdata_d = DIR_READ_VAL;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    a_dir_reads_ones: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr == OFS_DIR |=> reg_rdata == 8'hFF)
        else $error("direction read not all ones");

    a_latch_upper_zero: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr == OFS_LATCH |=> reg_rdata[7:3] == 5'h00)
        else $error("latch upper bits not zero");

    a_out_reads_latch: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr == OFS_LATCH && dir_q[0] |=> reg_rdata[0] == $past(latch_q[0]))
        else $error("output pin read not latch");

    a_in_reads_pin: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr == OFS_LATCH && !dir_q[2]
        |=> reg_rdata[2] == $past(pin_held_q[2]))
        else $error("input pin read not pin level");

    a_gpio_drive: assert property (@(posedge core_clk) disable iff (rst)
        pmode == PM_ACTIVE && !mux_ctl.rx_on_bit
        |=> pin_oe[1] == $past(dir_q[1]) && (!pin_oe[1] || pin_o[1] == $past(latch_q[1])))
        else $error("general pin drive wrong");

    a_tx_owns_pin: assert property (@(posedge core_clk) disable iff (rst)
        pmode == PM_ACTIVE && mux_ctl.tx_sel
        |=> pin_oe[2] && pin_o[2] == $past(ser_out.txd))
        else $error("transmit pin not driven");

    a_rx_input: assert property (@(posedge core_clk) disable iff (rst)
        pmode == PM_ACTIVE && mux_ctl.rx_on_bit |=> !pin_oe[1])
        else $error("receive pin driven");

    a_sck_modes: assert property (@(posedge core_clk) disable iff (rst)
        pmode == PM_ACTIVE && mux_ctl.clk_src_sel_hi |=> !pin_oe[0])
        else $error("clock input pin driven");

    a_sck_out: assert property (@(posedge core_clk) disable iff (rst)
        pmode == PM_ACTIVE && !mux_ctl.clk_src_sel_hi && mux_ctl.sync_sel_bit
        |=> pin_oe[0] && pin_o[0] == $past(ser_out.sck_out))
        else $error("clock output pin not driven");

    a_standby_hiz: assert property (@(posedge core_clk) disable iff (rst)
        pmode == PM_STANDBY |=> pin_oe == 3'h0)
        else $error("pins driven in standby");

    a_sleep_hold: assert property (@(posedge core_clk) disable iff (rst)
        pmode == PM_SLEEP |=> $stable(pin_oe) && $stable(pin_o))
        else $error("pins changed in sleep");

    a_latch_write: assert property (@(posedge core_clk) disable iff (rst)
        reg_wr && reg_addr == OFS_LATCH |=> latch_q == $past(reg_wdata[2:0]))
        else $error("latch write lost");

    a_dir_write: assert property (@(posedge core_clk) disable iff (rst)
        reg_wr && reg_addr == OFS_DIR |=> dir_q == $past(reg_wdata[2:0]))
        else $error("direction write lost");

    // other addresses leave the latch alone
    a_latch_kept: assert property (@(posedge core_clk) disable iff (rst)
        reg_wr && reg_addr != OFS_LATCH |=> $stable(latch_q))
        else $error("latch changed by foreign write");

    // other addresses leave the direction alone
    a_dir_kept: assert property (@(posedge core_clk) disable iff (rst)
        reg_wr && reg_addr != OFS_DIR |=> $stable(dir_q))
        else $error("direction changed by foreign write");

    // read data returns to zero once the read strobe drops
    a_rdata_idle: assert property (@(posedge core_clk) disable iff (rst)
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not idle");

    // unmapped reads return the idle value
    a_unmapped_read: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr != OFS_LATCH && reg_addr != OFS_DIR
        |=> reg_rdata == RD_UNMAPPED)
        else $error("unmapped read not idle value");

    a_out_reads_hi: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr == OFS_LATCH && dir_q[2] |=> reg_rdata[2] == $past(latch_q[2]))
        else $error("output pin two read not latch");

    a_out_reads_mid: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr == OFS_LATCH && dir_q[1] |=> reg_rdata[1] == $past(latch_q[1]))
        else $error("output pin one read not latch");

    // input bit 0 reads pin level
    a_in_reads_lo: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr == OFS_LATCH && !dir_q[0]
        |=> reg_rdata[0] == $past(pin_held_q[0]))
        else $error("input pin zero read not pin level");

    // input bit 1 reads pin level
    a_in_reads_mid: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr == OFS_LATCH && !dir_q[1]
        |=> reg_rdata[1] == $past(pin_held_q[1]))
        else $error("input pin one read not pin level");

    // pin 2 is general when transmit is off
    a_tx_gpio: assert property (@(posedge core_clk) disable iff (rst)
        pmode == PM_ACTIVE && !mux_ctl.tx_sel
        |=> pin_oe[2] == $past(dir_q[2]) && (!pin_oe[2] || pin_o[2] == $past(latch_q[2])))
        else $error("pin two general drive wrong");

    // receive line idles high when disabled
    a_rx_idle: assert property (@(posedge core_clk) disable iff (rst)
        !mux_ctl.rx_on_bit |=> ser_rxd)
        else $error("receive line not idle high");

    a_rx_follow: assert property (@(posedge core_clk) disable iff (rst)
        mux_ctl.rx_on_bit |=> ser_rxd == $past(pin_held_q[PIN_RX]))
        else $error("receive line not pin level");

    a_sck_in_follow: assert property (@(posedge core_clk) disable iff (rst)
        mux_ctl.clk_src_sel_hi |=> ser_sck_in == $past(pin_held_q[PIN_CLK]))
        else $error("clock input not pin level");

    a_sck_in_idle: assert property (@(posedge core_clk) disable iff (rst)
        !mux_ctl.clk_src_sel_hi |=> !ser_sck_in)
        else $error("clock input not quiet");

    // low select alone also drives the clock out
    a_sck_out_lo: assert property (@(posedge core_clk) disable iff (rst)
        pmode == PM_ACTIVE && !mux_ctl.clk_src_sel_hi && mux_ctl.clk_src_sel_lo
        |=> pin_oe[0] && pin_o[0] == $past(ser_out.sck_out))
        else $error("clock output by low select not driven");

    // no clock select leaves pin 0 general
    a_clk_pin_gpio: assert property (@(posedge core_clk) disable iff (rst)
        pmode == PM_ACTIVE && !mux_ctl.clk_src_sel_hi && !mux_ctl.clk_src_sel_lo
        && !mux_ctl.sync_sel_bit |=> pin_oe[0] == $past(dir_q[0]))
        else $error("pin zero general direction wrong");

    a_subactive_drive: assert property (@(posedge core_clk) disable iff (rst)
        pmode == PM_SUBACTIVE && !alt_sel[PIN_RX] |=> pin_oe[1] == $past(dir_q[1]))
        else $error("subactive pin drive wrong");

    // deeper holding modes keep pins too
    a_deep_hold: assert property (@(posedge core_clk) disable iff (rst)
        pmode == PM_SUBSLEEP || pmode == PM_WATCH
        |=> $stable(pin_oe) && $stable(pin_o))
        else $error("pins changed while holding");

    // sampled inputs frozen while holding, so readback stays put
    a_held_frozen: assert property (@(posedge core_clk) disable iff (rst)
        hold_mode |=> $stable(pin_held_q))
        else $error("held inputs changed");
endmodule : tbp_port

// *** tbp_sync3.sv ***
// Purpose: three-stage input synchroniser for the port pins
// Assumes: single clock, async active-high reset
// Notes: a change is accepted only when stages two and three agree
`timescale 1ns/1ps
module tbp_sync3 (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic din,
    output logic dout
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                dout <= s3_q;
            end
        end
    end
endmodule : tbp_sync3
